// [rtl/dm_addressing.sv]
// Data memory addressing: pointers, bank select, accumulator, program counter low byte
//
// How it works
// - Indirect port access uses its paired pointer's value as the data address.
// - Both pointers read and write like ordinary data memory registers.
// - First pointer always reaches bank 0; second follows the bank select bit.
// - Direct addressing of general memory always reaches bank 0.
// - Bank select bit 0: zero picks bank 0, one picks bank 1.
// - Bank select bits 7 to 1 are absent and read zero.
// - Reset returns bank 0, except watchdog reset in power down keeps it.
// - Special function registers decode the same whichever bank is selected.
// - ALU results land in the accumulator; no register-to-register move exists.
// - Writing the low program counter byte jumps within the current page.
// - Such a jump inserts one dummy instruction cycle.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dm_addressing (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wdt_pd_reset_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Core side
    input wire logic pc_step_i,
    output logic [dm_pkg::PC_W-1:0] pc_o,
    output logic pc_jump_o,
    output logic dummy_cycle_o,
    output logic bank_sel_o
);
    import dm_pkg::*;

    logic [7:0] mp0_r;
    logic [7:0] mp1_r;
    logic [7:0] acc_r;
    logic bank_r;
    logic [PC_W-1:0] pc_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic jump_r;
    logic dummy_r;
    pc_state_t pc_state_r;
    logic [7:0] ram_rd;

    function automatic logic sfr_hit(input logic [7:0] a);
        sfr_hit = (a <= SFR_TOP);
    endfunction

    function automatic logic ram_hit(input logic [7:0] a);
        ram_hit = (a >= RAM_BASE) && (a <= RAM_TOP);
    endfunction

    function automatic logic is_ind(input logic [7:0] a);
        is_ind = (a == A_IND0) || (a == A_IND1);
    endfunction

    // Bus request decode
    wire req = cyc_i & stb_i & ~ack_r;
    wire wr = req & we_i & sel_i[0];
    wire [7:0] dm_addr = adr_i[WB_ADR_MSB:WB_ADR_LSB];
    wire in_range = (adr_i[31:WB_ADR_MSB+1] == '0) && (adr_i[WB_ADR_LSB-1:0] == '0);
    wire via0 = (dm_addr == A_IND0);
    wire via1 = (dm_addr == A_IND1);
    wire direct = ~via0 & ~via1;

    // Effective address and bank
    wire [7:0] ea = via0 ? mp0_r : (via1 ? mp1_r : dm_addr);
    wire ea_bank = via1 & bank_r;
    // A pointer aimed at an indirect port itself reads zero and ignores writes
    wire ind_loop = ~direct & is_ind(ea);
    wire hit_sfr = in_range & sfr_hit(ea) & ~ind_loop;
    wire hit_ram = in_range & ram_hit(ea);

    // Special function register read selection, independent of bank
    wire [7:0] bank_rd = {BANK_RSVD, bank_r};
    wire [7:0] sfr_rd = (ea == A_PTR0) ? mp0_r :
                        (ea == A_PTR1) ? mp1_r :
                        (ea == A_BANK) ? bank_rd :
                        (ea == A_ACC) ? acc_r :
                        (ea == A_PCL) ? pc_r[PCL_W-1:0] : RD_NONE;
    wire [7:0] rd_byte = hit_sfr ? sfr_rd : (hit_ram ? ram_rd : RD_NONE);

    // Write strobes
    wire w_sfr = wr & hit_sfr;
    wire w_mp0 = w_sfr & (ea == A_PTR0);
    wire w_mp1 = w_sfr & (ea == A_PTR1);
    wire w_bank = w_sfr & (ea == A_BANK);
    wire w_acc = w_sfr & (ea == A_ACC);
    wire w_add = w_sfr & (ea == A_ADD);
    wire w_pcl = w_sfr & (ea == A_PCL);
    wire w_ram = wr & hit_ram;
    wire [7:0] wbyte = dat_i[7:0];
    // The adder writes only the accumulator; a store elsewhere needs a second access
    wire [7:0] alu_sum = 8'(acc_r + wbyte);
    wire [7:0] acc_nxt = w_add ? alu_sum : (w_acc ? wbyte : acc_r);
    wire [PC_W-1:0] pc_nxt = w_pcl ? {pc_r[PC_W-1:PCL_W], wbyte} :
                             (pc_step_i && pc_state_r == PC_RUN) ? 12'(pc_r + PC_STEP) : pc_r;

    dm_ram u_ram (
        .clk_i(clk_i),
        .we_i(w_ram),
        .bank_i(ea_bank),
        .addr_i(ea[RAM_AW-1:0]),
        .wdata_i(wbyte),
        .rdata_o(ram_rd)
    );

    // Bus answer: one wait cycle, ack for exactly one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= req;
            dat_r <= req ? {WB_PAD, rd_byte} : dat_r;
        end
    end

    // Pointers and accumulator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mp0_r <= PTR_RST;
            mp1_r <= PTR_RST;
            acc_r <= ACC_RST;
        end else begin
            if (w_mp0) begin
                mp0_r <= wbyte;
            end
            if (w_mp1) begin
                mp1_r <= wbyte;
            end
            acc_r <= acc_nxt;
        end
    end

    // Bank select survives a watchdog reset taken in power down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            if (!wdt_pd_reset_i) begin
                bank_r <= BANK_RST;
            end
        end else if (w_bank) begin
            bank_r <= dat_i[BANK_BIT];
        end
    end

    // Program counter; a written low byte costs one dummy cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_r <= PC_RST;
            pc_state_r <= PC_RUN;
            jump_r <= 1'b0;
            dummy_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            jump_r <= w_pcl;
            case (pc_state_r)
                PC_RUN: begin
                    if (w_pcl) begin
                        pc_state_r <= PC_DUMMY;
                        dummy_r <= 1'b1;
                    end
                end
                PC_DUMMY: begin
                    pc_state_r <= PC_RUN;
                    dummy_r <= 1'b0;
                end
                default: begin
                    pc_state_r <= PC_RUN;
                    dummy_r <= 1'b0;
                end
            endcase
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign pc_o = pc_r;
    assign pc_jump_o = jump_r;
    assign dummy_cycle_o = dummy_r;
    assign bank_sel_o = bank_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ind0_pointer_addr: assert property (
        w_ram && via0 |-> u_ram.addr_i == mp0_r[RAM_AW-1:0] && !u_ram.bank_i
    ) else $error("indirect port 0 did not use its pointer in bank 0");

    a_ind1_bank_follow: assert property (
        w_ram && via1 |-> u_ram.bank_i == bank_sel_o && u_ram.addr_i == mp1_r[RAM_AW-1:0]
    ) else $error("indirect port 1 ignored the bank select");

    a_direct_bank_zero: assert property (
        w_ram && direct |-> !u_ram.bank_i
    ) else $error("direct access left bank 0");

    a_pointer_rw_back: assert property (
        req && we_i && sel_i[0] && direct && dm_addr == A_PTR1 && in_range
        |=> mp1_r == $past(dat_i[7:0]) && ack_o
    ) else $error("pointer write did not stick");

    a_bank_bit_set: assert property (
        w_bank |=> bank_sel_o == $past(dat_i[BANK_BIT])
    ) else $error("bank select bit not taken from data bit 0");

    a_bank_rsvd_zero: assert property (
        req && !we_i && hit_sfr && ea == A_BANK |=> ack_o && dat_o[7:1] == BANK_RSVD
    ) else $error("reserved bank select bits read non-zero");

    // Reset checks carry an empty disable, otherwise the default one would mute them
    a_bank_rst_clear: assert property (
        @(posedge clk_i) disable iff (1'b0) rst_i && !wdt_pd_reset_i |=> !bank_sel_o
    ) else $error("reset did not return bank 0");

    a_bank_rst_keep: assert property (
        @(posedge clk_i) disable iff (1'b0) rst_i && wdt_pd_reset_i |=> $stable(bank_sel_o)
    ) else $error("watchdog power down reset changed the bank");

    a_sfr_any_bank: assert property (
        req && !we_i && direct && dm_addr == A_ACC && in_range |=> ack_o && dat_o[7:0] == $past(acc_r)
    ) else $error("special register read depended on bank");

    a_acc_add_result: assert property (
        w_add |=> acc_r == 8'($past(acc_r) + $past(dat_i[7:0]))
    ) else $error("ALU result missing from accumulator");

    a_pcl_page_jump: assert property (
        w_pcl |=> pc_jump_o && pc_o == {$past(pc_r[PC_W-1:PCL_W]), $past(dat_i[7:0])}
    ) else $error("low byte write did not jump within the page");

    a_pcl_dummy_one: assert property (
        w_pcl |=> dummy_cycle_o ##1 !dummy_cycle_o && $stable(pc_o)
    ) else $error("jump did not insert exactly one dummy cycle");

    a_ack_one_cycle: assert property (
        ack_o |=> !ack_o
    ) else $error("ack held longer than one cycle");

    // Bus handshake and read data
    a_ack_after_req: assert property (
        req |=> ack_o
    ) else $error("request not answered in the next cycle");

    a_ack_needs_req: assert property (
        !req |=> !ack_o
    ) else $error("ack given without a request");

    a_read_data_hold: assert property (
        !req |=> $stable(dat_o)
    ) else $error("read data changed without a request");

    a_upper_data_zero: assert property (
        ack_o |-> dat_o[31:8] == WB_PAD
    ) else $error("upper read data bits not zero");

    // Refused accesses leave every register alone
    a_unmapped_reads_zero: assert property (
        req && !we_i && !in_range |=> dat_o == {WB_PAD, RD_NONE}
    ) else $error("unmapped address read non-zero");

    a_ind_loop_read: assert property (
        req && !we_i && ind_loop |=> dat_o[7:0] == RD_NONE
    ) else $error("indirect port aimed at a port read non-zero");

    a_ind_loop_write: assert property (
        wr && ind_loop |=> $stable(mp0_r) && $stable(mp1_r) && $stable(acc_r) && $stable(bank_sel_o)
    ) else $error("indirect port aimed at a port took a write");

    a_sel_gates_write: assert property (
        req && we_i && !sel_i[0] |=> $stable(mp0_r) && $stable(mp1_r) && $stable(acc_r) && $stable(bank_sel_o)
    ) else $error("write without byte select changed a register");

    a_ram_write_window: assert property (
        u_ram.we_i |-> ea >= RAM_BASE && ea <= RAM_TOP
    ) else $error("memory written outside the general window");

    // Registers move only on their own strobe
    a_pointer0_rw: assert property (
        req && we_i && sel_i[0] && direct && dm_addr == A_PTR0 && in_range |=> mp0_r == $past(dat_i[7:0])
    ) else $error("pointer 0 write did not stick");

    a_pointer_read_back: assert property (
        req && !we_i && hit_sfr && ea == A_PTR1 |=> ack_o && dat_o[7:0] == $past(mp1_r)
    ) else $error("pointer read did not return its value");

    a_pointer0_hold: assert property (
        !w_mp0 |=> $stable(mp0_r)
    ) else $error("pointer 0 changed without a write");

    a_pointer1_hold: assert property (
        !w_mp1 |=> $stable(mp1_r)
    ) else $error("pointer 1 changed without a write");

    a_bank_read_bit: assert property (
        req && !we_i && hit_sfr && ea == A_BANK |=> dat_o[BANK_BIT] == $past(bank_r)
    ) else $error("bank select read did not show the bank bit");

    a_bank_hold: assert property (
        !w_bank |=> $stable(bank_sel_o)
    ) else $error("bank select changed without a write");

    a_acc_load: assert property (
        w_acc |=> acc_r == $past(dat_i[7:0])
    ) else $error("accumulator load lost");

    a_acc_hold: assert property (
        !w_acc && !w_add |=> $stable(acc_r)
    ) else $error("accumulator changed without a load or sum");

    // Program counter sequencing
    a_pc_step_run: assert property (
        pc_step_i && !w_pcl && pc_state_r == PC_RUN |=> pc_o == PC_W'($past(pc_r) + PC_STEP)
    ) else $error("program counter did not step");

    a_pc_hold_idle: assert property (
        !pc_step_i && !w_pcl |=> $stable(pc_o)
    ) else $error("program counter moved without a step");

    a_dummy_with_jump: assert property (
        dummy_cycle_o |-> pc_jump_o
    ) else $error("dummy cycle without a jump");

    a_dummy_state_flag: assert property (
        pc_state_r == PC_DUMMY |-> dummy_cycle_o
    ) else $error("dummy state not flagged");

    a_jump_one_pulse: assert property (
        pc_jump_o |=> !pc_jump_o
    ) else $error("jump pulse held longer than one cycle");

    // Covers for the main scenarios
    c_pcl_jump: cover property (w_pcl ##1 dummy_cycle_o);
    c_bank1_write: cover property (w_ram && via1 && bank_r);
    c_wdt_keep: cover property (@(posedge clk_i) disable iff (1'b0) rst_i && wdt_pd_reset_i && bank_r);
    c_acc_add: cover property (w_add);
    c_ind_loop: cover property (req && ind_loop);
endmodule
`default_nettype wire

// [rtl/dm_pkg.sv]
// Constants shared by the data memory addressing block
package dm_pkg;
    // Widths
    localparam int DM_AW = 8;
    localparam int RAM_AW = 6;
    localparam int PC_W = 12;
    localparam int PCL_W = 8;
    // Wishbone word index field of adr_i
    localparam int WB_ADR_LSB = 2;
    localparam int WB_ADR_MSB = 9;
    // Special function register addresses in the data memory space
    localparam logic [7:0] A_IND0 = 8'h00;
    localparam logic [7:0] A_PTR0 = 8'h01;
    localparam logic [7:0] A_IND1 = 8'h02;
    localparam logic [7:0] A_PTR1 = 8'h03;
    localparam logic [7:0] A_BANK = 8'h04;
    localparam logic [7:0] A_ACC = 8'h05;
    localparam logic [7:0] A_PCL = 8'h06;
    localparam logic [7:0] A_ADD = 8'h07;
    // Area limits
    localparam logic [7:0] SFR_TOP = 8'h3f;
    localparam logic [7:0] RAM_BASE = 8'h40;
    localparam logic [7:0] RAM_TOP = 8'h7f;
    // Bank select field and reset values
    localparam int BANK_BIT = 0;
    localparam logic BANK_RST = 1'b0;
    localparam logic [6:0] BANK_RSVD = 7'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [11:0] PC_RST = 12'h000;
    localparam logic [11:0] PC_STEP = 12'h001;
    localparam logic [7:0] RD_NONE = 8'h00;
    localparam logic [23:0] WB_PAD = 24'h000000;
    // Program counter sequencing
    typedef enum logic [0:0] {
        PC_RUN = 1'b0,
        PC_DUMMY = 1'b1
    } pc_state_t;
endpackage

// [rtl/dm_ram.sv]
// Two banks of general purpose data memory
`timescale 1ns/100ps
`default_nettype none
module dm_ram (
    // Clock
    input wire logic clk_i,
    // Write and read port
    input wire logic we_i,
    input wire logic bank_i,
    input wire logic [dm_pkg::RAM_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    import dm_pkg::*;

    // Bank bit on top so both banks share one array
    logic [7:0] mem [0:(2**(RAM_AW+1))-1];
    wire [RAM_AW:0] idx = {bank_i, addr_i};

    assign rdata_o = mem[idx];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[idx] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// [tb/dm_addressing_tb.sv]
// Self-checking bench for the data memory addressing block
`timescale 1ns/100ps
`default_nettype none
module dm_addressing_tb;
    import dm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wdt_pd_reset_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [31:0] adr_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic pc_step_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic pc_jump_o;
    logic dummy_cycle_o;
    logic bank_sel_o;
    logic [PC_W-1:0] pc_o;
    logic [PC_W-1:0] pc_req;
    logic [PC_W-1:0] pc_ack;
    logic jmp_ack;
    logic dum_ack;
    logic [31:0] rd;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    dm_addressing u_dut (.clk_i(clk_i), .rst_i(rst_i), .wdt_pd_reset_i(wdt_pd_reset_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pc_step_i(pc_step_i), .pc_o(pc_o), .pc_jump_o(pc_jump_o), .dummy_cycle_o(dummy_cycle_o),
        .bank_sel_o(bank_sel_o));

    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] ad(input logic [7:0] idx);
        return {22'h000000, idx, 2'h0};
    endfunction

    // Entered right after a rising edge; ack and data are taken at the rising edge that samples ack high
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic s0);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= {3'h0, s0};
        dat_i <= {24'h000000, d};
        @(posedge clk_i);
        pc_req = pc_o;
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        pc_ack = pc_o;
        jmp_ack = pc_jump_o;
        dum_ack = dummy_cycle_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, ad(idx), d, 1'b1);
    endtask

    task automatic rdr(input logic [7:0] idx);
        wb(1'b0, ad(idx), 8'h00, 1'b1);
    endtask

    task automatic do_reset(input logic wd);
        rst_i <= 1'b1;
        wdt_pd_reset_i <= wd;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wdt_pd_reset_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic t_bank();
        rdr(A_BANK);
        chk("bank reset", rd, 32'h0);
        wr(A_BANK, 8'hff);
        rdr(A_BANK);
        chk("bank reserved bits", rd, 32'h1);
        chk("bank pin", {31'h0, bank_sel_o}, 32'h1);
        wb(1'b1, ad(A_BANK), 8'h00, 1'b0);
        chk("bank sel off", {31'h0, bank_sel_o}, 32'h1);
        wr(A_PTR0, 8'h5a);
        rdr(A_PTR0);
        chk("pointer 0", rd, 32'h5a);
        wb(1'b0, 32'h400, 8'h00, 1'b1);
        chk("unmapped", rd, 32'h0);
    endtask

    // Bank 1 is selected on entry
    task automatic t_ram();
        wr(8'h40, 8'ha5);
        wr(A_PTR1, 8'h40);
        wr(A_IND1, 8'h3c);
        rdr(8'h40);
        chk("direct bank 0", rd, 32'ha5);
        rdr(A_IND1);
        chk("indirect bank 1", rd, 32'h3c);
        wr(A_PTR0, 8'h40);
        rdr(A_IND0);
        chk("indirect 0", rd, 32'ha5);
        wr(A_PTR1, A_PTR0);
        rdr(A_IND1);
        chk("sfr in bank 1", rd, 32'h40);
        // A pointer aimed at the other port: the write is dropped and the read gives zero
        wr(A_PTR0, A_IND1);
        wr(A_IND0, 8'h77);
        rdr(A_IND0);
        chk("port on port", rd, 32'h0);
        wr(A_BANK, 8'h00);
        wr(A_PTR1, 8'h40);
        rdr(A_IND1);
        chk("indirect 1 bank 0", rd, 32'ha5);
    endtask

    task automatic t_alu();
        wr(A_ACC, 8'h10);
        wr(A_ADD, 8'h05);
        rdr(A_ACC);
        chk("accumulator sum", rd, 32'h15);
        rdr(A_ADD);
        chk("adder port read", rd, 32'h0);
    endtask

    // Stepping stays on, so the dummy cycle shows as one missing increment
    task automatic t_pc();
        repeat (260) @(posedge clk_i);
        wr(A_PCL, 8'h20);
        chk("jump target", {20'h0, pc_ack}, {20'h0, pc_req[11:8], 8'h20});
        chk("jump pulse", {31'h0, jmp_ack}, 32'h1);
        chk("dummy pulse", {31'h0, dum_ack}, 32'h1);
        @(negedge clk_i);
        chk("after dummy", {20'h0, pc_o}, {20'h0, pc_req[11:8], 8'h21});
        chk("dummy ended", {31'h0, dummy_cycle_o}, 32'h0);
        @(posedge clk_i);
        pc_step_i <= 1'b0;
        @(posedge clk_i);
        pc_req = pc_o;
        repeat (4) @(posedge clk_i);
        chk("pc held without step", {20'h0, pc_o}, {20'h0, pc_req});
        pc_step_i <= 1'b1;
    endtask

    task automatic t_reset();
        wr(A_BANK, 8'h01);
        do_reset(1'b1);
        chk("watchdog keeps bank", {31'h0, bank_sel_o}, 32'h1);
        do_reset(1'b0);
        chk("reset clears bank", {31'h0, bank_sel_o}, 32'h0);
        rdr(A_PTR0);
        chk("pointer reset", rd, 32'h0);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        pc_step_i <= 1'b1;
        @(posedge clk_i);
        t_bank();
        t_ram();
        t_alu();
        t_pc();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
